// >>> icp_ping_engine.sv
// echo engine: periodic echo requests with round-trip timing, echo answering
// assumes an Avalon-MM master on the register side and a framing layer on the net side
`timescale 1ns/1ps
module icp_ping_engine
  import icp_pkg::*;
#(
  parameter int CYC_PER_MS = `ICP_MS_NS / `ICP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // avalon-mm slave
  input  wire logic [`ICP_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // interrupt
  output logic                       irq,
  // message transmit
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic      [7:0]            tx_type,
  output logic      [31:0]           tx_addr,
  output logic      [`ICP_SEQ_W-1:0] tx_seq,
  // message receive
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_type,
  input  wire logic [31:0]           rx_addr,
  input  wire logic [`ICP_SEQ_W-1:0] rx_seq
);

  localparam logic [`ICP_PERIOD_W-1:0] PMIN = `ICP_PERIOD_W'(`ICP_PERIOD_MIN_MS);
  localparam logic [`ICP_PERIOD_W-1:0] PMAX = `ICP_PERIOD_W'(`ICP_PERIOD_MAX_MS);
  localparam logic [`ICP_PERIOD_W-1:0] PRST = `ICP_PERIOD_W'(`ICP_PERIOD_RST_MS);

  initial
  begin
    if (CYC_PER_MS < 2)
      $error("icp_ping_engine: CYC_PER_MS must be at least 2");
  end

  icp_state_s q_r;
  icp_state_s q_nxt;
  icp_tick_if tk ();

  icp_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tk      (tk.gen)
  );

  logic                  active;
  logic                  reply_hit;
  logic                  req_in;
  logic [`ICP_IRQ_W-1:0] ev;
  logic [`ICP_IRQ_W-1:0] clr;

  // no run-state input: the engine never looks at the controller mode
  assign active    = q_r.enable && (q_r.target != 32'h00000000);
  // reply must match the outstanding request; stale ones fall through
  // a reply in the cycle that halts pinging is ignored, as the state drops to idle
  assign reply_hit = active && rx_valid && (rx_type == `ICP_TYPE_ECHO_REPLY) && (q_r.st == ICP_ST_AWAIT)
                     && (rx_seq == q_r.seq) && (rx_addr == q_r.target);
  assign req_in    = rx_valid && (rx_type == `ICP_TYPE_ECHO_REQ);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // out-of-range periods are clamped rather than refused, so software always reads the value in use
  function automatic logic [`ICP_PERIOD_W-1:0] clamp_period(input logic [31:0] v);
    logic [`ICP_PERIOD_W-1:0] r;
    r = v[`ICP_PERIOD_W-1:0];
    if (v < 32'(`ICP_PERIOD_MIN_MS))
      r = PMIN;
    else if (v > 32'(`ICP_PERIOD_MAX_MS))
      r = PMAX;
    return r;
  endfunction

  always_comb
  begin
    logic [31:0] cur;
    cur   = 32'h00000000;
    q_nxt = q_r;
    ev    = '0;
    clr   = '0;

    // register bus: accept cycle drops waitrequest, data cycle commits
    if (q_r.waitreq && (avs_read || avs_write))
    begin
      q_nxt.waitreq = 1'b0;
      if (avs_read)
      begin
        unique case (avs_address)
          `ICP_OFS_CTRL:     q_nxt.rdata = {31'h00000000, q_r.enable};
          `ICP_OFS_TARGET:   q_nxt.rdata = q_r.target;
          `ICP_OFS_PERIOD:   q_nxt.rdata = 32'(q_r.period);
          `ICP_OFS_RESULT:   q_nxt.rdata = q_r.result;
          `ICP_OFS_IRQ_STAT: q_nxt.rdata = 32'(q_r.irq_stat);
          `ICP_OFS_IRQ_EN:   q_nxt.rdata = 32'(q_r.irq_en);
          `ICP_OFS_STATUS:   q_nxt.rdata = {28'h0000000, q_r.tx_valid, q_r.rep_pend, q_r.st};
          default:           q_nxt.rdata = 32'h00000000;
        endcase
      end
    end
    else if (!q_r.waitreq)
    begin
      q_nxt.waitreq = 1'b1;
      if (avs_write)
      begin
        unique case (avs_address)
          `ICP_OFS_CTRL:
          begin
            cur          = be_merge({31'h00000000, q_r.enable}, avs_writedata, avs_byteenable);
            q_nxt.enable = cur[`ICP_CTRL_EN_BIT];
          end
          `ICP_OFS_TARGET:   q_nxt.target = be_merge(q_r.target, avs_writedata, avs_byteenable);
          `ICP_OFS_PERIOD:
          begin
            cur          = be_merge(32'(q_r.period), avs_writedata, avs_byteenable);
            q_nxt.period = clamp_period(cur);
          end
          `ICP_OFS_IRQ_CLR:  clr = avs_writedata[`ICP_IRQ_W-1:0];
          `ICP_OFS_IRQ_EN:   q_nxt.irq_en = avs_writedata[`ICP_IRQ_W-1:0];
          default:           cur = 32'h00000000;
        endcase
      end
    end

    // transmit channel: handshake frees it
    if (q_r.tx_valid && tx_ready)
      q_nxt.tx_valid = 1'b0;

    // millisecond counter since the last request, saturating
    if (tk.tick && (q_r.ms_cnt != PMAX))
      q_nxt.ms_cnt = q_r.ms_cnt + `ICP_PERIOD_W'(1);

    // request sequencing
    if (!active)
      q_nxt.st = ICP_ST_IDLE;
    else
    begin
      unique case (q_r.st)
        ICP_ST_IDLE:
          q_nxt.st = ICP_ST_SEND;
        ICP_ST_GAP:
          if (tk.tick && (q_r.ms_cnt >= q_r.period - `ICP_PERIOD_W'(1)))
            q_nxt.st = ICP_ST_SEND;
        ICP_ST_SEND:
          // answers to others go first; a request waits until the reply slot is empty and the channel is free
          if (!q_r.tx_valid && !q_r.rep_pend)
          begin
            q_nxt.seq         = q_r.seq + `ICP_SEQ_W'(1);
            q_nxt.tx_valid    = 1'b1;
            q_nxt.tx_is_reply = 1'b0;
            q_nxt.tx_type     = `ICP_TYPE_ECHO_REQ;
            q_nxt.tx_addr     = q_r.target;
            q_nxt.tx_seq      = q_r.seq + `ICP_SEQ_W'(1);
            q_nxt.ms_cnt      = '0;
            q_nxt.st          = ICP_ST_AWAIT;
          end
        ICP_ST_AWAIT:
          // ends on the matching reply, or times out at a tick once ms_cnt reaches the period
          if (reply_hit)
          begin
            q_nxt.st = ICP_ST_GAP;
            if (q_r.ms_cnt > q_r.period)
            begin
              q_nxt.result = `ICP_RESULT_TIMEOUT;
              ev[`ICP_IRQ_TIMEOUT] = 1'b1;
            end
            else
            begin
              q_nxt.result = 32'(q_r.ms_cnt);
              ev[`ICP_IRQ_DONE] = 1'b1;
            end
          end
          else if (tk.tick && (q_r.ms_cnt >= q_r.period))
          begin
            // timeout comes one ms after the next period would start, so send again at once
            q_nxt.result = `ICP_RESULT_TIMEOUT;
            ev[`ICP_IRQ_TIMEOUT] = 1'b1;
            q_nxt.st = ICP_ST_SEND;
          end
      endcase
    end

    // echo answering, independent of enable and target
    if (q_r.rep_pend && !q_r.tx_valid)
    begin
      q_nxt.rep_pend    = 1'b0;
      q_nxt.tx_valid    = 1'b1;
      q_nxt.tx_is_reply = 1'b1;
      q_nxt.tx_type     = `ICP_TYPE_ECHO_REPLY;
      q_nxt.tx_addr     = q_r.rep_addr;
      q_nxt.tx_seq      = q_r.rep_seq;
      ev[`ICP_IRQ_ANSWERED] = 1'b1;
    end
    // single reply slot: a request arriving while it stays full (not emptied this cycle) is dropped
    if (req_in && !q_nxt.rep_pend)
    begin
      q_nxt.rep_pend = 1'b1;
      q_nxt.rep_addr = rx_addr;
      q_nxt.rep_seq  = rx_seq;
    end

    // sticky status: a new event beats a clear in the same cycle
    q_nxt.irq_stat = (q_r.irq_stat & ~clr) | ev;
    q_nxt.irq      = |(q_nxt.irq_stat & q_nxt.irq_en);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q_r         <= '0;
      q_r.waitreq <= 1'b1;
      q_r.target  <= `ICP_RST_TARGET;
      q_r.result  <= `ICP_RST_RESULT;
      q_r.period  <= PRST;
      q_r.st      <= ICP_ST_IDLE;
      q_r.tx_type <= `ICP_TYPE_ECHO_REPLY;
    end
    else
      q_r <= q_nxt;
  end

  assign avs_readdata    = q_r.rdata;
  assign avs_waitrequest = q_r.waitreq;
  assign irq             = q_r.irq;
  assign tx_valid        = q_r.tx_valid;
  assign tx_type         = q_r.tx_type;
  assign tx_addr         = q_r.tx_addr;
  assign tx_seq          = q_r.tx_seq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_req_load;
    !q_r.tx_valid ##1 (q_r.tx_valid && !q_r.tx_is_reply);
  endsequence

  sequence s_answer_taken;
    req_in && !q_r.rep_pend && !q_r.tx_valid && (q_r.st != ICP_ST_SEND);
  endsequence

  AST_REQ_TO_TARGET: assert property (s_req_load |-> q_r.tx_addr == $past(q_r.target))
    else $error("request sent to an address other than the target");
  AST_RTT_STORED: assert property (reply_hit && (q_r.ms_cnt <= q_r.period)
                                   |=> q_r.result == $past(32'(q_r.ms_cnt)))
    else $error("round trip not stored in result");
  AST_PERIOD_RANGE: assert property ((q_r.period >= PMIN) && (q_r.period <= PMAX))
    else $error("period outside its legal range");
  AST_TIMEOUT_MINUS1: assert property ((q_r.st == ICP_ST_AWAIT) && active && !reply_hit && tk.tick
                                       && (q_r.ms_cnt >= q_r.period)
                                       |=> (q_r.result == `ICP_RESULT_TIMEOUT) && (q_r.st == ICP_ST_SEND))
    else $error("timeout did not store minus one");
  AST_START_ON_TARGET: assert property ((q_r.st == ICP_ST_IDLE) && active |=> q_r.st == ICP_ST_SEND)
    else $error("nonzero target did not start pinging");
  AST_NO_REQ_IDLE: assert property (s_req_load |-> $past(active, 2))
    else $error("request sent while zero target or disabled");
  AST_HALT: assert property (!active |=> q_r.st == ICP_ST_IDLE)
    else $error("pinging did not halt");
  AST_ANSWER: assert property (s_answer_taken |=> q_r.rep_pend ##1
                               (q_r.tx_valid && q_r.tx_is_reply && (q_r.tx_type == `ICP_TYPE_ECHO_REPLY)
                                && (q_r.tx_addr == $past(rx_addr, 2))))
    else $error("echo request not answered");
  AST_OTHER_TYPES: assert property (rx_valid && (rx_type != `ICP_TYPE_ECHO_REQ) && !q_r.rep_pend
                                    |=> !q_r.rep_pend)
    else $error("non-echo message was acted on");
  AST_LATE_DROP: assert property (rx_valid && (q_r.st != ICP_ST_AWAIT) |=> $stable(q_r.result))
    else $error("late reply changed result");
  AST_IRQ_LEVEL: assert property (irq == |(q_r.irq_stat & q_r.irq_en))
    else $error("interrupt level does not follow status and enable");
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

// >>> icp_consts.svh
// constants for the echo (ping) engine: register map, fields, encodings, timing
// assumes inclusion by bare name from the package and the bench
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH

// register byte offsets, one aligned 32-bit word each
`define ICP_ADDR_W         5
`define ICP_OFS_CTRL       5'h00
`define ICP_OFS_TARGET     5'h04
`define ICP_OFS_PERIOD     5'h08
`define ICP_OFS_RESULT     5'h0C
`define ICP_OFS_IRQ_STAT   5'h10
`define ICP_OFS_IRQ_CLR    5'h14
`define ICP_OFS_IRQ_EN     5'h18
`define ICP_OFS_STATUS     5'h1C

// field positions
`define ICP_CTRL_EN_BIT    0
`define ICP_IRQ_W          3
`define ICP_IRQ_DONE       0
`define ICP_IRQ_TIMEOUT    1
`define ICP_IRQ_ANSWERED   2

// message type codes on the network port
`define ICP_TYPE_ECHO_REQ   8'h08
`define ICP_TYPE_ECHO_REPLY 8'h00

// values
`define ICP_RESULT_TIMEOUT 32'hFFFFFFFF
`define ICP_RST_TARGET     32'h00000000
`define ICP_RST_RESULT     32'h00000000
`define ICP_SEQ_W          16
`define ICP_PERIOD_W       17

// timing: period in ms, clock in ns
`define ICP_PERIOD_MIN_MS  100
`define ICP_PERIOD_MAX_MS  100000
`define ICP_PERIOD_RST_MS  1000
`define ICP_MS_NS          1000000
`define ICP_CLK_PERIOD_NS  25

`endif

// >>> icp_pkg.sv
// types shared by the echo engine and its millisecond time base
// assumes icp_consts.svh is on the include path
package icp_pkg;
  `include "icp_consts.svh"

  typedef enum logic [1:0] {
    ICP_ST_IDLE  = 2'b00,
    ICP_ST_GAP   = 2'b01,
    ICP_ST_SEND  = 2'b10,
    ICP_ST_AWAIT = 2'b11
  } icp_state_e;

  typedef struct packed {
    logic                     waitreq;
    logic [31:0]              rdata;
    logic                     enable;
    logic [31:0]              target;
    logic [`ICP_PERIOD_W-1:0] period;
    logic [31:0]              result;
    logic [`ICP_IRQ_W-1:0]    irq_stat;
    logic [`ICP_IRQ_W-1:0]    irq_en;
    logic                     irq;
    icp_state_e               st;
    logic [`ICP_PERIOD_W-1:0] ms_cnt;
    logic [`ICP_SEQ_W-1:0]    seq;
    logic                     rep_pend;
    logic [31:0]              rep_addr;
    logic [`ICP_SEQ_W-1:0]    rep_seq;
    logic                     tx_valid;
    logic                     tx_is_reply;
    logic [7:0]               tx_type;
    logic [31:0]              tx_addr;
    logic [`ICP_SEQ_W-1:0]    tx_seq;
  } icp_state_s;
endpackage

// >>> icp_tick_if.sv
// carrier of the millisecond strobe between time base and engine
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface icp_tick_if;
  logic tick;
  modport gen (output tick);
  modport sink (input tick);
endinterface

// >>> icp_ms_tick.sv
// millisecond time base: one-cycle strobe every CYC_PER_MS clocks
// assumes sys_clk and synchronous active-high rst
`timescale 1ns/1ps
module icp_ms_tick #(
  parameter int CYC_PER_MS = 40000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // strobe out
  icp_tick_if.gen   tk
);
  import icp_pkg::*;

  localparam int CW = $clog2(CYC_PER_MS);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } icp_tick_s;

  icp_tick_s q_r;
  icp_tick_s q_nxt;

  initial
  begin
    if (CYC_PER_MS < 2)
      $error("icp_ms_tick: CYC_PER_MS must be at least 2");
  end

  always_comb
  begin
    q_nxt      = q_r;
    q_nxt.tick = 1'b0;
    if (q_r.cnt == CW'(CYC_PER_MS - 1))
    begin
      q_nxt.cnt  = '0;
      q_nxt.tick = 1'b1;
    end
    else
      q_nxt.cnt = q_r.cnt + CW'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign tk.tick = q_r.tick;
endmodule

// >>> icp_remote.sv
// remote station model: answers echo requests after a set delay, injects messages
// assumes the engine's clock and that its outputs settle before the falling edge
`timescale 1ns/1ps
module icp_remote (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // bench controls
  input  wire logic        answer_en,
  input  wire logic        stall,
  input  wire logic [15:0] delay_cyc,
  input  wire logic        inj,
  input  wire logic [7:0]  inj_type,
  input  wire logic [31:0] inj_addr,
  input  wire logic [15:0] inj_seq,
  // engine link
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_type,
  input  wire logic [31:0] tx_addr,
  input  wire logic [15:0] tx_seq,
  output logic             rx_valid,
  output logic [7:0]       rx_type,
  output logic [31:0]      rx_addr,
  output logic [15:0]      rx_seq
);
  int          cyc = 0;
  int          q_due[$];
  logic [47:0] q_msg[$];

  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    {rx_type, rx_addr, rx_seq} = '0;
  end

  // several replies may be in flight when the delay exceeds the period
  always @(negedge sys_clk)
    if (!rst && answer_en && tx_valid === 1'b1 && tx_ready && tx_type === 8'h08)
    begin
      q_due.push_back(cyc + int'(delay_cyc));
      q_msg.push_back({tx_addr, tx_seq});
    end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    tx_ready <= !stall;
    rx_valid <= 1'b0;
    // idle fields invert each cycle, so they match the last message every second cycle
    {rx_type, rx_addr, rx_seq} <= ~{rx_type, rx_addr, rx_seq};
    if (inj)
    begin
      rx_valid <= 1'b1;
      {rx_type, rx_addr, rx_seq} <= {inj_type, inj_addr, inj_seq};
    end
    else if (q_due.size() > 0 && q_due[0] <= cyc)
    begin
      rx_valid <= 1'b1;
      {rx_type, rx_addr, rx_seq} <= {8'h00, q_msg[0]};
      q_msg.delete(0);
      q_due.delete(0);
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the echo engine, ms tick shortened to 4 clocks
// assumes icp_pkg, icp_consts.svh and the remote model are compiled first
`timescale 1ns/1ps
`include "icp_consts.svh"
module tb;
  import icp_pkg::*;
  localparam logic [31:0] TGT_A = 32'h0A000001;
  localparam logic [31:0] TGT_B = 32'h0A000002;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        tx_valid, tx_ready, rx_valid;
  logic [7:0]  tx_type, rx_type;
  logic [31:0] tx_addr, rx_addr;
  logic [15:0] tx_seq, rx_seq;
  logic        answer_en = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] delay_cyc = 16'd40;
  logic        inj = 1'b0;
  logic [7:0]  inj_type = '0;
  logic [31:0] inj_addr = '0;
  logic [15:0] inj_seq = '0;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0, n_req = 0, n_rep = 0, t_req = 0, gap = 0, base = 0;
  logic [31:0] req_addr, rep_addr;
  logic [15:0] rep_seq;

  always #12.5 sys_clk = ~sys_clk;

  icp_ping_engine #(.CYC_PER_MS(4)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_type(tx_type), .tx_addr(tx_addr),
    .tx_seq(tx_seq), .rx_valid(rx_valid), .rx_type(rx_type), .rx_addr(rx_addr), .rx_seq(rx_seq));

  icp_remote i_remote (
    .sys_clk(sys_clk), .rst(rst), .answer_en(answer_en), .stall(stall), .delay_cyc(delay_cyc),
    .inj(inj), .inj_type(inj_type), .inj_addr(inj_addr), .inj_seq(inj_seq),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_type(tx_type), .tx_addr(tx_addr),
    .tx_seq(tx_seq), .rx_valid(rx_valid), .rx_type(rx_type), .rx_addr(rx_addr), .rx_seq(rx_seq));

  // log every accepted message; falling edge avoids racing the registers
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(negedge sys_clk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (tx_type === `ICP_TYPE_ECHO_REQ)
      begin
        n_req++;
        gap = cyc - t_req;
        t_req = cyc;
        req_addr = tx_addr;
      end
      else
      begin
        n_rep++;
        rep_addr = tx_addr;
        rep_seq = tx_seq;
      end
    end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is seen low, released on that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("bus answer", 1, n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    check(what, e, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic inject(input logic [7:0] t, input logic [31:0] a, input logic [15:0] s);
    @(posedge sys_clk);
    inj <= 1'b1;
    {inj_type, inj_addr, inj_seq} <= {t, a, s};
    @(posedge sys_clk);
    inj <= 1'b0;
  endtask

  task automatic t_reset;
    logic [31:0] e [8] = '{0, 0, 32'h3E8, 0, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++)
      rdchk(5'(i * 4), e[i], "reset value");
  endtask

  task automatic t_period;
    logic [31:0] w [3] = '{32'd50, 32'd200000, 32'd100};
    logic [31:0] e [3] = '{32'd100, 32'd100000, 32'd100};
    for (int i = 0; i < 3; i++)
    begin
      wr(`ICP_OFS_PERIOD, w[i]);
      rdchk(`ICP_OFS_PERIOD, e[i], "period clamp");
    end
  endtask

  task automatic t_ping;
    logic [31:0] q;
    wr(`ICP_OFS_IRQ_EN, 32'h7);
    answer_en <= 1'b1;
    wr(`ICP_OFS_CTRL, 32'h1);
    wr(`ICP_OFS_TARGET, TGT_A);
    wait_irq(1000);
    check("request address", TGT_A, req_addr);
    rdchk(`ICP_OFS_IRQ_STAT, 32'h1, "done flag");
    bus(1'b0, `ICP_OFS_RESULT, '0, q);
    check("round trip near 10 ms", 1, q >= 9 && q <= 11);
    wr(`ICP_OFS_IRQ_EN, 32'h0);
    idle(1);
    check("masked irq", 0, irq);
    wr(`ICP_OFS_IRQ_EN, 32'h7);
    idle(1);
    check("unmasked irq", 1, irq);
    wr(`ICP_OFS_IRQ_CLR, 32'h7);
    idle(1);
    check("cleared irq", 0, irq);
    wait_irq(1000);
    check("request interval", 1, gap >= 392 && gap <= 408);
  endtask

  // replies due at 150 ms land after each 100 ms timeout and must be dropped
  task automatic t_timeout;
    answer_en <= 1'b0;
    idle(500);
    delay_cyc <= 16'd600;
    answer_en <= 1'b1;
    wr(`ICP_OFS_IRQ_CLR, 32'h7);
    idle(1200);
    rdchk(`ICP_OFS_IRQ_STAT, 32'h2, "timeout flag only");
    rdchk(`ICP_OFS_RESULT, `ICP_RESULT_TIMEOUT, "timeout result");
  endtask

  task automatic t_stop;
    wr(`ICP_OFS_TARGET, 32'h0);
    idle(700);
    base = n_req;
    idle(1000);
    check("requests after zero target", base, n_req);
    rdchk(`ICP_OFS_STATUS, 32'h0, "idle status");
    wr(`ICP_OFS_CTRL, 32'h0);
    wr(`ICP_OFS_TARGET, TGT_A);
    idle(1000);
    check("requests while disabled", base, n_req);
    wr(`ICP_OFS_CTRL, 32'h1);
    idle(60);
    check("request after enable", base + 1, n_req);
    wr(`ICP_OFS_CTRL, 32'h0);
  endtask

  task automatic t_answer;
    logic [7:0] k [4] = '{8'h03, 8'h0D, 8'h11, 8'h00};
    wr(`ICP_OFS_IRQ_CLR, 32'h7);
    base = n_rep;
    stall <= 1'b1;
    inject(`ICP_TYPE_ECHO_REQ, TGT_B, 16'h1234);
    idle(10);
    check("reply held while stalled", 1, tx_valid);
    stall <= 1'b0;
    idle(10);
    check("reply count", base + 1, n_rep);
    check("reply address", TGT_B, rep_addr);
    check("reply seq", 32'h1234, rep_seq);
    rdchk(`ICP_OFS_IRQ_STAT, 32'h4, "answered flag");
    for (int i = 0; i < 4; i++)
    begin
      inject(k[i], TGT_B, 16'h0042);
      idle(20);
      check("other kinds ignored", base + 1, n_rep);
    end
  endtask

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_period;
    t_ping;
    t_timeout;
    t_stop;
    t_answer;
    summarize;
  end

  // the scenarios need about 5100 cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    $display("watchdog expired");
    summarize;
  end
endmodule
